// ==== tog_core.sv ====
`timescale 1ns/1ns
module tog_core #(
	parameter int CNT_W   = 16,
	parameter int WIDTH_W = 16
) (
	input  wire logic                          clk_sys,
	input  wire logic                          rst_n,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic                               pready,
	output logic [31:0]                        prdata,
	output logic                               pslverr,
	input  wire logic                          arm_event,
	input  wire logic                          trig_event,
	input  wire tog_pkg::tog_act_t             act_done,
	input  wire logic                          sine_marker,
	input  wire logic                          wave_point,
	output tog_pkg::tog_act_t                  act_start,
	output logic                               internal_bus_line_one,
	output logic                               internal_bus_line_two,
	output logic                               lan_trigger,
	output logic [tog_pkg::NUM_PINS-1:0]       dio_pin_o,
	output logic [tog_pkg::NUM_PINS-1:0]       dio_pin_oe,
	output logic                               busy
);
	// ==========================================
	// Input synchronisers for external events
	logic [2:0] arm_sync_reg, arm_sync_next;
	logic [2:0] trg_sync_reg, trg_sync_next;
	logic       arm_pulse, trg_pulse, arm_lvl_reg, arm_lvl_next, trg_lvl_reg, trg_lvl_next;

	always_comb begin
		arm_sync_next = {arm_sync_reg[1:0], arm_event};
		trg_sync_next = {trg_sync_reg[1:0], trig_event};
		arm_lvl_next  = (arm_sync_reg[1] == arm_sync_reg[2]) ? arm_sync_reg[2] : arm_lvl_reg;
		trg_lvl_next  = (trg_sync_reg[1] == trg_sync_reg[2]) ? trg_sync_reg[2] : trg_lvl_reg;
		arm_pulse     = arm_lvl_next & ~arm_lvl_reg;
		trg_pulse     = trg_lvl_next & ~trg_lvl_reg;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			arm_sync_reg <= 3'h0;
			trg_sync_reg <= 3'h0;
			arm_lvl_reg  <= 1'b0;
			trg_lvl_reg  <= 1'b0;
		end else begin
			arm_sync_reg <= arm_sync_next;
			trg_sync_reg <= trg_sync_next;
			arm_lvl_reg  <= arm_lvl_next;
			trg_lvl_reg  <= trg_lvl_next;
		end
	end

	// ==========================================
	// Registers
	logic [31:0]                        ctrl_reg,      ctrl_next;
	logic [4:0]                         route_reg [tog_pkg::NUM_EV];
	logic [4:0]                         route_next [tog_pkg::NUM_EV];
	logic [3*tog_pkg::NUM_PINS-1:0]     pincfg_reg,    pincfg_next;
	logic [tog_pkg::NUM_PINS-1:0]       pinfunc_reg,   pinfunc_next;
	logic [WIDTH_W-1:0]                 pwidth_reg,    pwidth_next;
	logic [CNT_W-1:0]                   armcnt_reg,    armcnt_next;
	logic [CNT_W-1:0]                   trgcnt_reg,    trgcnt_next;
	logic [9:0]                         waveroute_reg, waveroute_next;
	logic [31:0]                        evcount_reg,   evcount_next;
	logic                               wr_en;

	assign wr_en   = psel & penable & pwrite;
	assign pready  = 1'b1;

	function automatic logic [4:0] field5(input logic [31:0] d, input int i);
		field5 = d[i*5 +: 5];
	endfunction

	// ==========================================
	// Sequencer
	tog_pkg::tog_state_t         st_reg, st_next;
	logic [CNT_W-1:0]            arm_i_reg, arm_i_next;
	logic [CNT_W-1:0]            trg_i_reg, trg_i_next;
	logic [tog_pkg::NUM_EV-1:0]  ev;
	logic                        loop_meas;
	tog_pkg::tog_act_t           start_next, start_reg;

	assign loop_meas = ctrl_reg[tog_pkg::CTRL_LOOP_MEAS];

	always_comb begin
		st_next    = st_reg;
		arm_i_next = arm_i_reg;
		trg_i_next = trg_i_reg;
		ev         = '0;
		start_next = '0;
		if (ctrl_reg[tog_pkg::CTRL_ABORT]) begin
			st_next = tog_pkg::TOG_IDLE;
		end else begin
			case (st_reg)
				tog_pkg::TOG_IDLE: begin
					if (ctrl_reg[tog_pkg::CTRL_INIT]) begin
						st_next    = tog_pkg::TOG_ARM;
						arm_i_next = '0;
					end
				end
				tog_pkg::TOG_ARM: begin
					if (arm_pulse) begin
						ev[tog_pkg::EV_ARM_START] = 1'b1;
						st_next    = tog_pkg::TOG_TRG;
						trg_i_next = '0;
					end
				end
				tog_pkg::TOG_TRG: begin
					if (trg_pulse) begin
						if (trg_i_reg == '0) begin
							ev[tog_pkg::EV_TRG_START] = 1'b1;
						end
						ev[tog_pkg::EV_SRC_START]  = 1'b1;
						ev[tog_pkg::EV_MEAS_START] = 1'b1;
						start_next = '{src_busy: 1'b1, meas_busy: 1'b1};
						st_next    = loop_meas ? tog_pkg::TOG_MEAS : tog_pkg::TOG_SRC;
					end
				end
				tog_pkg::TOG_SRC, tog_pkg::TOG_MEAS: begin
					if (act_done.src_busy) begin
						ev[tog_pkg::EV_SRC_END] = 1'b1;
					end
					if (act_done.meas_busy) begin
						ev[tog_pkg::EV_MEAS_END] = 1'b1;
					end
					if ((st_reg == tog_pkg::TOG_SRC && act_done.src_busy) ||
					    (st_reg == tog_pkg::TOG_MEAS && act_done.meas_busy)) begin
						trg_i_next = trg_i_reg + CNT_W'(1);
						st_next    = (trg_i_reg + CNT_W'(1) >= trgcnt_reg) ?
							tog_pkg::TOG_TRG_END : tog_pkg::TOG_TRG;
					end
				end
				tog_pkg::TOG_TRG_END: begin
					ev[tog_pkg::EV_TRG_END] = 1'b1;
					arm_i_next = arm_i_reg + CNT_W'(1);
					st_next    = (arm_i_reg + CNT_W'(1) >= armcnt_reg) ?
						tog_pkg::TOG_ARM_END : tog_pkg::TOG_ARM;
				end
				tog_pkg::TOG_ARM_END: begin
					ev[tog_pkg::EV_ARM_END] = 1'b1;
					st_next = tog_pkg::TOG_IDLE;
				end
				default: st_next = tog_pkg::TOG_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg    <= tog_pkg::TOG_IDLE;
			arm_i_reg <= '0;
			trg_i_reg <= '0;
			start_reg <= '0;
		end else begin
			st_reg    <= st_next;
			arm_i_reg <= arm_i_next;
			trg_i_reg <= trg_i_next;
			start_reg <= start_next;
		end
	end

	assign act_start = start_reg;
	assign busy      = (st_reg != tog_pkg::TOG_IDLE);

	// ==========================================
	// Event routing: OR of every enabled event aimed at each destination
	logic [tog_pkg::NUM_DEST-1:0] dest_fire, dest_after;
	logic [tog_pkg::NUM_DEST-1:0] assigned;
	logic [4:0]                   ev_en_cnt;

	always_comb begin
		dest_fire  = '0;
		dest_after = '0;
		assigned   = '0;
		ev_en_cnt  = '0;
		for (int e = 0; e < tog_pkg::NUM_EV; e++) begin
			if (ctrl_reg[e] && route_reg[e] < 5'(tog_pkg::NUM_DEST)) begin
				assigned[route_reg[e]] = 1'b1;
				if (ev[e]) begin
					dest_fire[route_reg[e]]  = 1'b1;
					dest_after[route_reg[e]] = dest_after[route_reg[e]] | e[0];
					ev_en_cnt = ev_en_cnt + 5'(1);
				end
			end
		end
		// Waveform markers only where no enabled loop/action event is routed
		if (waveroute_reg[4:0] < 5'(tog_pkg::NUM_DEST) && !assigned[waveroute_reg[4:0]] && sine_marker) begin
			dest_fire[waveroute_reg[4:0]] = 1'b1;
		end
		if (waveroute_reg[9:5] < 5'(tog_pkg::NUM_DEST) && !assigned[waveroute_reg[9:5]] && wave_point) begin
			dest_fire[waveroute_reg[9:5]] = 1'b1;
		end
	end

	logic [2:0] bus_reg, bus_next;
	always_comb begin
		bus_next = {dest_fire[tog_pkg::DEST_LAN], dest_fire[tog_pkg::DEST_INTERNAL_BUS_LINE_TWO], dest_fire[tog_pkg::DEST_INTERNAL_BUS_LINE_ONE]};
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_reg <= 3'h0;
		end else begin
			bus_reg <= bus_next;
		end
	end

	assign internal_bus_line_one = bus_reg[0];
	assign internal_bus_line_two = bus_reg[1];
	assign lan_trigger           = bus_reg[2];

	genvar p;
	generate
		for (p = 0; p < tog_pkg::NUM_PINS; p++) begin : g_pin
			tog_pin_drv #(.WIDTH_W(WIDTH_W)) u_pin (
				.clk_sys  (clk_sys),
				.rst_n    (rst_n),
				.fire     (dest_fire[tog_pkg::DEST_PIN0+p]),
				.is_after (dest_after[tog_pkg::DEST_PIN0+p]),
				.enabled  (pinfunc_reg[p]),
				.cfg      (pincfg_reg[3*p +: 3]),
				.width    (pwidth_reg),
				.pin_o    (dio_pin_o[p]),
				.pin_oe   (dio_pin_oe[p])
			);
		end
	endgenerate

	// ==========================================
	// APB register file
	always_comb begin
		ctrl_next      = ctrl_reg;
		ctrl_next[tog_pkg::CTRL_INIT]  = 1'b0;
		ctrl_next[tog_pkg::CTRL_ABORT] = 1'b0;
		route_next     = route_reg;
		pincfg_next    = pincfg_reg;
		pinfunc_next   = pinfunc_reg;
		pwidth_next    = pwidth_reg;
		armcnt_next    = armcnt_reg;
		trgcnt_next    = trgcnt_reg;
		waveroute_next = waveroute_reg;
		evcount_next   = evcount_reg + 32'(ev_en_cnt);
		if (wr_en) begin
			if (paddr == tog_pkg::ADDR_CTRL) begin
				ctrl_next = {21'h0, pwdata[10:0]};
			end else if (paddr == tog_pkg::ADDR_ROUTE) begin
				for (int e = 0; e < 6; e++) begin
					route_next[e] = field5(pwdata, e);
				end
			end else if (paddr == tog_pkg::ADDR_PINCFG) begin
				pincfg_next[31:0] = pwdata;
			end else if (paddr == tog_pkg::ADDR_PWIDTH) begin
				pwidth_next = pwdata[WIDTH_W-1:0];
				pincfg_next[41:32] = pwdata[25:16];
			end else if (paddr == tog_pkg::ADDR_ARMCNT) begin
				armcnt_next = pwdata[CNT_W-1:0];
			end else if (paddr == tog_pkg::ADDR_TRGCNT) begin
				trgcnt_next = pwdata[CNT_W-1:0];
			end else if (paddr == tog_pkg::ADDR_PINFUNC) begin
				pinfunc_next = pwdata[tog_pkg::NUM_PINS-1:0];
			end else if (paddr == tog_pkg::ADDR_WAVEROUTE) begin
				waveroute_next = pwdata[9:0];
				route_next[6]  = pwdata[20:16];
				route_next[7]  = pwdata[28:24];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg      <= 32'h0;
			for (int e = 0; e < tog_pkg::NUM_EV; e++) begin
				route_reg[e] <= 5'h1F;
			end
			pincfg_reg    <= '0;
			pinfunc_reg   <= tog_pkg::PINFUNC_RST;
			pwidth_reg    <= WIDTH_W'(tog_pkg::PULSE_CYC);
			armcnt_reg    <= 16'h0001;
			trgcnt_reg    <= 16'h0001;
			waveroute_reg <= 10'h3FF;
			evcount_reg   <= 32'h0;
		end else begin
			ctrl_reg      <= ctrl_next;
			route_reg     <= route_next;
			pincfg_reg    <= pincfg_next;
			pinfunc_reg   <= pinfunc_next;
			pwidth_reg    <= pwidth_next;
			armcnt_reg    <= armcnt_next;
			trgcnt_reg    <= trgcnt_next;
			waveroute_reg <= waveroute_next;
			evcount_reg   <= evcount_next;
		end
	end

	always_comb begin
		prdata  = 32'h0;
		pslverr = 1'b0;
		if (paddr == tog_pkg::ADDR_CTRL) begin
			prdata = ctrl_reg;
		end else if (paddr == tog_pkg::ADDR_ROUTE) begin
			prdata = {2'h0, route_reg[5], route_reg[4], route_reg[3], route_reg[2], route_reg[1], route_reg[0]};
		end else if (paddr == tog_pkg::ADDR_PINCFG) begin
			prdata = 32'(pincfg_reg);
		end else if (paddr == tog_pkg::ADDR_PWIDTH) begin
			prdata = 32'({pincfg_reg[41:32], pwidth_reg});
		end else if (paddr == tog_pkg::ADDR_ARMCNT) begin
			prdata = 32'(armcnt_reg);
		end else if (paddr == tog_pkg::ADDR_TRGCNT) begin
			prdata = 32'(trgcnt_reg);
		end else if (paddr == tog_pkg::ADDR_STATUS) begin
			prdata = {8'h0, trg_i_reg[7:0], arm_i_reg[7:0], 5'h0, st_reg};
		end else if (paddr == tog_pkg::ADDR_EVCOUNT) begin
			prdata = evcount_reg;
		end else if (paddr == tog_pkg::ADDR_PINFUNC) begin
			prdata = 32'(pinfunc_reg);
		end else if (paddr == tog_pkg::ADDR_WAVEROUTE) begin
			prdata = {3'h0, route_reg[7], 3'h0, route_reg[6], 6'h0, waveroute_reg};
		end else begin
			pslverr = psel & penable;
		end
	end
endmodule

// ==== tog_core_properties.sv ====
`timescale 1ns/1ns
module tog_core_properties (
	input wire logic              clk_sys,
	input wire logic              rst_n,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire tog_pkg::tog_act_t act_start,
	input wire logic [13:0]       dio_pin_o,
	input wire logic [13:0]       dio_pin_oe,
	input wire logic              busy
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// ==========================================
	// Bus and sequencer steps
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_init;
		s_acc ##0 (pwrite && paddr == tog_pkg::ADDR_CTRL && pwdata[tog_pkg::CTRL_INIT]);
	endsequence
	AST_READY: assert property (s_acc |-> pready)
		else $error("access phase without ready");
	AST_ERR_MAP: assert property (s_acc ##0 (paddr > 8'h24) |-> pslverr)
		else $error("unmapped access not refused");
	AST_ERR_OK: assert property (s_acc ##0 (paddr <= 8'h24 && paddr[1:0] == 2'h0) |-> !pslverr)
		else $error("mapped access refused");
	AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	AST_ACT_ONE: assert property (act_start != 2'h0 |=> act_start == 2'h0)
		else $error("action start longer than one cycle");
	AST_ACT_BUSY: assert property (act_start != 2'h0 |-> busy)
		else $error("action start while idle");
	AST_INIT_GO: assert property ((s_init ##0 (!busy && !pwdata[tog_pkg::CTRL_ABORT])) |-> ##2 busy)
		else $error("init did not start sequencer");
	AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(psel && penable && pwrite && paddr == tog_pkg::ADDR_CTRL, 2))
		else $error("sequencer started without init");
	AST_OE_HOLD: assert property (!(psel && penable && pwrite) |=> $stable(dio_pin_oe))
		else $error("pin enable changed without write");
	AST_RESET_IDLE: assert property ($rose(rst_n) |-> dio_pin_o == 14'h3FFF && !busy)
		else $error("bad state after reset");
endmodule

// ==== tog_far_model.sv ====
`timescale 1ns/1ns
module tog_far_model (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              slow,
	input  wire logic              clr,
	input  wire tog_pkg::tog_act_t act_start,
	output tog_pkg::tog_act_t      act_done,
	input  wire logic              line_one,
	input  wire logic              line_two,
	input  wire logic              lan,
	input  wire logic [13:0]       pin_o,
	input  wire logic [13:0]       pin_oe,
	output int                     n_one,
	output int                     n_two,
	output int                     n_lan,
	output int                     n_act,
	output int                     n_hi0,
	output int                     n_edge [14]
);
	tog_pkg::tog_act_t held;
	int                wait_c;
	logic [13:0]       last;
	// ==========================================
	// Action units: answer each start after a short or long busy time
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			act_done <= 2'h0;
			wait_c <= 0;
		end else begin
			act_done <= 2'h0;
			if (wait_c != 0)
				wait_c <= wait_c - 1;
			if (wait_c == 1)
				act_done <= held;
			if (act_start != 2'h0) begin
				held <= act_start;
				wait_c <= slow ? 12 : 2;
			end
		end
	end
	// ==========================================
	// Listener: cycles high on lines, level changes on driven pins
	always @(posedge clk_sys) begin
		if (clr) begin
			n_one <= 0;
			n_two <= 0;
			n_lan <= 0;
			n_act <= 0;
			n_hi0 <= 0;
			n_edge <= '{default: 0};
		end else begin
			n_one <= n_one + int'(line_one === 1'b1);
			n_two <= n_two + int'(line_two === 1'b1);
			n_lan <= n_lan + int'(lan === 1'b1);
			n_act <= n_act + int'(act_start != 2'h0);
			n_hi0 <= n_hi0 + int'(pin_oe[0] && pin_o[0] === 1'b1);
			for (int i = 0; i < 14; i++)
				if (pin_oe[i] && pin_o[i] !== last[i])
					n_edge[i] <= n_edge[i] + 1;
		end
		last <= pin_o;
	end
endmodule

// ==== tog_pin_drv.sv ====
`timescale 1ns/1ns
module tog_pin_drv #(
	parameter int WIDTH_W = 16
) (
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	input  wire logic               fire,
	input  wire logic               is_after,
	input  wire logic               enabled,
	input  wire logic [2:0]         cfg,
	input  wire logic [WIDTH_W-1:0] width,
	output logic                    pin_o,
	output logic                    pin_oe
);
	// ==========================================
	// Pulse/edge shaping for one digital trigger pin
	logic               active_reg,  active_next;
	logic [WIDTH_W-1:0] cnt_reg,     cnt_next;
	logic               level_reg,   level_next;
	logic               timing_ok;

	always_comb begin
		timing_ok   = ~cfg[tog_pkg::PCFG_AFTER] | is_after;
		active_next = active_reg;
		cnt_next    = cnt_reg;
		level_next  = level_reg;
		if (!enabled) begin
			active_next = 1'b0;
			level_next  = 1'b0;
		end else if (fire && timing_ok) begin
			if (cfg[tog_pkg::PCFG_PULSE]) begin
				active_next = 1'b1;
				cnt_next    = (width == '0) ? WIDTH_W'(1) : width;
			end else begin
				level_next = ~level_reg; // Edge type toggles line
			end
		end else if (active_reg) begin
			cnt_next = cnt_reg - WIDTH_W'(1);
			if (cnt_reg == WIDTH_W'(1)) begin
				active_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			active_reg <= 1'b0;
			cnt_reg    <= '0;
			level_reg  <= 1'b0;
		end else begin
			active_reg <= active_next;
			cnt_reg    <= cnt_next;
			level_reg  <= level_next;
		end
	end

	// Idle level follows polarity: negative idles high
	assign pin_o  = (active_reg | level_reg) ^ ~cfg[tog_pkg::PCFG_POS];
	assign pin_oe = enabled;
endmodule

// ==== tog_pkg.sv ====
package tog_pkg;
	// ==========================================
	// Register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_ROUTE     = 8'h04;
	localparam logic [7:0] ADDR_PINCFG    = 8'h08;
	localparam logic [7:0] ADDR_PWIDTH    = 8'h0C;
	localparam logic [7:0] ADDR_ARMCNT    = 8'h10;
	localparam logic [7:0] ADDR_TRGCNT    = 8'h14;
	localparam logic [7:0] ADDR_STATUS    = 8'h18;
	localparam logic [7:0] ADDR_EVCOUNT   = 8'h1C;
	localparam logic [7:0] ADDR_PINFUNC   = 8'h20;
	localparam logic [7:0] ADDR_WAVEROUTE = 8'h24;

	// ==========================================
	// Event enables and control bits in CTRL, bit positions
	localparam int EV_ARM_START   = 0;
	localparam int EV_ARM_END     = 1;
	localparam int EV_TRG_START   = 2;
	localparam int EV_TRG_END     = 3;
	localparam int EV_SRC_START   = 4;
	localparam int EV_SRC_END     = 5;
	localparam int EV_MEAS_START  = 6;
	localparam int EV_MEAS_END    = 7;
	localparam int NUM_EV         = 8;
	localparam int CTRL_LOOP_MEAS = 8;
	localparam int CTRL_INIT      = 9;
	localparam int CTRL_ABORT     = 10;

	// ==========================================
	// Destinations
	localparam int NUM_PINS = 14;
	localparam int NUM_DEST = 17;
	localparam int DEST_INTERNAL_BUS_LINE_ONE = 0;
	localparam int DEST_INTERNAL_BUS_LINE_TWO = 1;
	localparam int DEST_LAN  = 2;
	localparam int DEST_PIN0 = 3;

	// ==========================================
	// Pin configuration fields (PINCFG bits [3p+2:3p]): type, polarity, timing
	localparam int PCFG_W       = 3;
	localparam int PCFG_PULSE   = 0;
	localparam int PCFG_POS     = 1;
	localparam int PCFG_AFTER   = 2;
	localparam logic [13:0] PINFUNC_RST = 14'h0000;

	// ==========================================
	// Timing
	localparam int CLK_HZ        = 25000000;
	localparam int PULSE_US      = 100;
	localparam int PULSE_CYC     = (PULSE_US * (CLK_HZ / 1000000));
	localparam logic [15:0] PWIDTH_RST = 16'(PULSE_CYC);

	typedef enum logic [2:0] {
		TOG_IDLE, TOG_ARM, TOG_TRG, TOG_SRC, TOG_MEAS, TOG_TRG_END, TOG_ARM_END
	} tog_state_t;

	typedef struct packed {
		logic src_busy;
		logic meas_busy;
	} tog_act_t;

	typedef struct packed {
		logic       fire;
		logic       after;
	} tog_ev_t;
endpackage

// ==== trigger_output_event_generator_bench.sv ====
`timescale 1ns/1ns
module trigger_output_event_generator_bench;
	logic              clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, rdat;
	logic              arm_event, trig_event, sine_marker, wave_point, slow, clr, rerr;
	logic              busy, line_one, line_two, lan;
	logic [13:0]       pin_o, pin_oe;
	tog_pkg::tog_act_t act_done, act_start;
	int                n_one, n_two, n_lan, n_act, n_hi0, errors, n_checks;
	int                n_edge [14];

	tog_core u_tog_core (
		.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .arm_event(arm_event),
		.trig_event(trig_event), .act_done(act_done), .sine_marker(sine_marker),
		.wave_point(wave_point), .act_start(act_start),
		.internal_bus_line_one(line_one), .internal_bus_line_two(line_two),
		.lan_trigger(lan), .dio_pin_o(pin_o), .dio_pin_oe(pin_oe), .busy(busy)
	);
	tog_far_model u_tog_far_model (
		.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .clr(clr),
		.act_start(act_start), .act_done(act_done), .line_one(line_one),
		.line_two(line_two), .lan(lan), .pin_o(pin_o), .pin_oe(pin_oe),
		.n_one(n_one), .n_two(n_two), .n_lan(n_lan), .n_act(n_act),
		.n_hi0(n_hi0), .n_edge(n_edge)
	);
	// ==========================================
	// Shared tasks
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task trig();
		trig_event <= 1'b1;
		repeat (4) @(posedge clk_sys);
		trig_event <= 1'b0;
		repeat (30) @(posedge clk_sys);
	endtask
	task run(input int t);
		arm_event <= 1'b1;
		repeat (4) @(posedge clk_sys);
		arm_event <= 1'b0;
		repeat (8) @(posedge clk_sys);
		repeat (t) trig();
	endtask
	task wait_idle();
		for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk_sys);
		repeat (12) @(posedge clk_sys);
	endtask
	task clear();
		clr <= 1'b1;
		@(posedge clk_sys);
		clr <= 1'b0;
	endtask
	// ==========================================
	// Scenarios
	task t_defaults();
		xfer(1'b0, tog_pkg::ADDR_PWIDTH, 32'h0);
		chk(rdat, {16'h0, tog_pkg::PWIDTH_RST});
		xfer(1'b0, tog_pkg::ADDR_PINCFG, 32'h0);
		chk(rdat, 32'h0);
		xfer(1'b0, tog_pkg::ADDR_TRGCNT, 32'h0);
		chk(rdat, 32'h1);
		xfer(1'b1, 8'h30, 32'hFFFFFFFF);
		chk({31'h0, rerr}, 32'h1);
		chk({18'h0, pin_o}, 32'h3FFF);
		chk({18'h0, pin_oe}, 32'h0);
	endtask
	task t_events();
		xfer(1'b1, tog_pkg::ADDR_ROUTE, {2'h0, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00});
		xfer(1'b1, tog_pkg::ADDR_WAVEROUTE, {3'h0, 5'h07, 3'h0, 5'h06, 6'h00, 5'h1F, 5'h1F});
		xfer(1'b1, tog_pkg::ADDR_PINFUNC, 32'h1F);
		xfer(1'b1, tog_pkg::ADDR_ARMCNT, 32'h1);
		xfer(1'b1, tog_pkg::ADDR_TRGCNT, 32'h2);
		clear();
		xfer(1'b1, tog_pkg::ADDR_CTRL, 32'h2FF);
		run(2);
		wait_idle();
		chk(n_one, 1);
		chk(n_two, 1);
		chk(n_lan, 1);
		chk(n_edge[0], 1);
		chk(n_edge[1], 2);
		chk(n_edge[2], 2);
		chk(n_edge[3], 2);
		chk(n_edge[4], 2);
		xfer(1'b0, tog_pkg::ADDR_EVCOUNT, 32'h0);
		chk(rdat, 32'h0000000C);
	endtask
	task t_loops();
		xfer(1'b1, tog_pkg::ADDR_ARMCNT, 32'h2);
		xfer(1'b1, tog_pkg::ADDR_TRGCNT, 32'h3);
		slow <= 1'b1;
		clear();
		xfer(1'b1, tog_pkg::ADDR_CTRL, 32'h210);
		run(3);
		run(2);
		chk({31'h0, busy}, 32'h1);
		trig();
		wait_idle();
		chk({31'h0, busy}, 32'h0);
		chk(n_act, 6);
		chk(n_edge[1], 6);
		slow <= 1'b0;
	endtask
	task t_pulse();
		xfer(1'b1, tog_pkg::ADDR_PINFUNC, 32'h0);
		xfer(1'b1, tog_pkg::ADDR_PINFUNC, 32'h1);
		xfer(1'b1, tog_pkg::ADDR_PINCFG, 32'h1F);
		xfer(1'b1, tog_pkg::ADDR_PWIDTH, 32'h6);
		xfer(1'b1, tog_pkg::ADDR_ROUTE, {2'h0, 5'h03, 5'h03, 5'h1F, 5'h1F, 5'h1F, 5'h1F});
		xfer(1'b1, tog_pkg::ADDR_ARMCNT, 32'h1);
		xfer(1'b1, tog_pkg::ADDR_TRGCNT, 32'h1);
		clear();
		chk({18'h0, pin_oe}, 32'h1);
		chk({31'h0, pin_o[0]}, 32'h0);
		xfer(1'b1, tog_pkg::ADDR_CTRL, 32'h230);
		run(1);
		wait_idle();
		chk(n_edge[0], 2);
		chk(n_hi0, 6);
	endtask
	task t_marker();
		xfer(1'b1, tog_pkg::ADDR_PINFUNC, 32'h0);
		xfer(1'b1, tog_pkg::ADDR_ROUTE, {2'h0, 5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h00});
		xfer(1'b1, tog_pkg::ADDR_WAVEROUTE, {22'h0, 5'h00, 5'h01});
		xfer(1'b1, tog_pkg::ADDR_CTRL, 32'h1);
		clear();
		sine_marker <= 1'b1;
		wave_point <= 1'b1;
		@(posedge clk_sys);
		sine_marker <= 1'b0;
		wave_point <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chk(n_two, 1);
		chk(n_one, 0);
	endtask
	task close_out();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==========================================
	// Clock, reset, sequence and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{arm_event, trig_event, sine_marker, wave_point, slow, clr} = 6'h0;
		errors = 0;
		n_checks = 0;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_defaults();
		t_events();
		t_loops();
		t_pulse();
		t_marker();
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		close_out();
	end
endmodule

bind tog_core tog_core_properties u_tog_core_properties (
	.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .act_start(act_start), .dio_pin_o(dio_pin_o),
	.dio_pin_oe(dio_pin_oe), .busy(busy)
);
